// ### inc/memory_size_pkg.sv
package memory_size_pkg;

   // Register addresses on the byte-wide memory space
   localparam logic [15:0] memory_size_addr    = 16'hFFF0;
   localparam logic [15:0] expansion_size_addr = 16'hFFF4;

   // Reset values
   localparam logic [7:0] memory_size_reset      = 8'hCF;
   localparam logic [7:0] expansion_reset_flash  = 8'h08;
   localparam logic [7:0] expansion_reset_mask   = 8'h0C;

   // Field positions
   localparam int fast_field_msb    = 7;
   localparam int fast_field_lsb    = 5;
   localparam int program_field_msb = 3;
   localparam int program_field_lsb = 0;

   // Legal field codes
   localparam logic [3:0] program_code_32k = 4'h8;
   localparam logic [3:0] program_code_48k = 4'hC;
   localparam logic [3:0] program_code_60k = 4'hF;
   localparam logic [2:0] fast_code_1024   = 3'h6;
   localparam logic [3:0] capacity_code_480  = 4'hB;
   localparam logic [3:0] capacity_code_2016 = 4'h8;

   // Expansion capacity field position
   localparam int capacity_field_msb = 3;
   localparam int capacity_field_lsb = 0;

   // Write masks: bit 4 and the expansion upper nibble are reserved
   localparam logic [7:0] memory_size_write_mask = 8'hEF;
   localparam logic [7:0] expansion_write_mask   = 8'h0F;

   // Values shown when nothing is selected or mapped
   localparam logic [7:0]  read_idle_value = 8'h00;
   localparam logic [15:0] size_none       = 16'h0000;

   // Decoded memory map sizes
   localparam logic [15:0] program_bytes_32k = 16'h8000;
   localparam logic [15:0] program_bytes_48k = 16'hC000;
   localparam logic [15:0] program_bytes_60k = 16'hF000;
   localparam logic [15:0] fast_bytes_1024   = 16'h0400;
   localparam logic [15:0] capacity_bytes_480  = 16'h01E0;
   localparam logic [15:0] capacity_bytes_2016 = 16'h07E0;

   // Byte-wide register access from the processor
   typedef struct packed
   {
      logic        write;
      logic        read;
      logic [15:0] addr;
      logic [7:0]  wdata;
   } cpu_access_type;

   // Resulting memory map seen by the address decoder
   typedef struct packed
   {
      logic [15:0] program_bytes;
      logic [15:0] fast_work_bytes;
      logic [15:0] expansion_bytes;
      logic        setting_illegal;
   } memory_map_type;

endpackage

// ### design/memory_size_config_regs.sv
`timescale 1ns/1ps

module memory_size_config_regs
#(
   parameter bit flash_variant = 1'b1
)
(
   input  wire logic                           clock,
   input  wire logic                           reset_n,
   input  wire memory_size_pkg::cpu_access_type cpu_access,
   output logic [7:0]                          read_data,
   output memory_size_pkg::memory_map_type     memory_map
);
   import memory_size_pkg::*;

   // Behaviour notes for users of the map outputs:
   // a write lands in its register at the edge that takes it,
   // and the memory map follows one edge later from its own flops.
   // A read and a write in one cycle return the old contents.
   // Prohibited codes are stored as written, decode to no memory
   // and raise the illegal-setting flag, so software can see them.
   // Reserved bits are cleared on the way in and always read zero.
   //
   // The registers are reached only through the byte access port.
   // Other addresses are ignored on write and read back as zero.
   // The map outputs are meant for the address decoder, which must
   // treat a size of zero as no memory present in that area.
   // There is no write protection: any byte write takes effect.

   // Expansion reset value is fixed per build by the product parameter
   localparam logic [7:0] expansion_reset_value =
      flash_variant ? expansion_reset_flash : expansion_reset_mask;

   // Stored configuration registers and their next values
   logic [7:0]     memory_size_register_q;
   logic [7:0]     memory_size_register_d;
   logic [7:0]     expansion_size_register_q;
   logic [7:0]     expansion_size_register_d;

   // Output flops and their next values
   logic [7:0]     read_data_q;
   logic [7:0]     read_data_d;
   memory_map_type memory_map_q;
   memory_map_type memory_map_d;

   // Address match, shared by the read and the write path
   function automatic logic register_hit
   (
      input logic [15:0] addr,
      input logic [15:0] target
   );
      return addr == target;
   endfunction

   // Program size code to bytes; a prohibited code maps no memory
   function automatic logic [15:0] program_bytes_of
   (
      input logic [3:0] code
   );
      logic [15:0] bytes;
      bytes = size_none;
      case (code)
         program_code_32k: bytes = program_bytes_32k;
         program_code_48k: bytes = program_bytes_48k;
         program_code_60k: bytes = program_bytes_60k;
         default:          bytes = size_none;
      endcase
      return bytes;
   endfunction

   // Fast work memory code to bytes; only one code is allowed
   function automatic logic [15:0] fast_bytes_of
   (
      input logic [2:0] code
   );
      logic [15:0] bytes;
      bytes = size_none;
      case (code)
         fast_code_1024: bytes = fast_bytes_1024;
         default:        bytes = size_none;
      endcase
      return bytes;
   endfunction

   // Expansion capacity code to bytes; a prohibited code maps none
   function automatic logic [15:0] capacity_bytes_of
   (
      input logic [3:0] code
   );
      logic [15:0] bytes;
      bytes = size_none;
      case (code)
         capacity_code_480:  bytes = capacity_bytes_480;
         capacity_code_2016: bytes = capacity_bytes_2016;
         default:            bytes = size_none;
      endcase
      return bytes;
   endfunction

   // Register selects on the byte address
   wire memory_size_hit = register_hit(cpu_access.addr, memory_size_addr);
   wire expansion_hit   = register_hit(cpu_access.addr, expansion_size_addr);

   // Write and read strobes per register
   wire memory_size_write = cpu_access.write && memory_size_hit;
   wire expansion_write   = cpu_access.write && expansion_hit;
   wire memory_size_read  = cpu_access.read && memory_size_hit;
   wire expansion_read    = cpu_access.read && expansion_hit;

   // Write data with the reserved bits cleared on the way in
   wire [7:0] memory_size_wvalue =
      cpu_access.wdata & memory_size_write_mask;
   wire [7:0] expansion_wvalue =
      cpu_access.wdata & expansion_write_mask;

   // Next register values: one byte write replaces the whole register
   assign memory_size_register_d =
      memory_size_write ? memory_size_wvalue : memory_size_register_q;
   assign expansion_size_register_d =
      expansion_write ? expansion_wvalue : expansion_size_register_q;

   // Field views of the stored registers
   wire [3:0] program_memory_size_field =
      memory_size_register_q[program_field_msb:program_field_lsb];
   wire [2:0] fast_work_memory_size_field =
      memory_size_register_q[fast_field_msb:fast_field_lsb];
   wire [3:0] expansion_capacity_field =
      expansion_size_register_q[capacity_field_msb:capacity_field_lsb];

   // Sizes for the memory map; a 59.5K part still uses the 60K code
   wire [15:0] program_bytes =
      program_bytes_of(program_memory_size_field);
   wire [15:0] fast_bytes =
      fast_bytes_of(fast_work_memory_size_field);
   wire [15:0] expansion_bytes =
      capacity_bytes_of(expansion_capacity_field);

   // A prohibited code in any field is flagged to the decoder
   wire program_bad   = program_bytes == size_none;
   wire fast_bad      = fast_bytes == size_none;
   wire expansion_bad = expansion_bytes == size_none;
   wire setting_bad   = program_bad || fast_bad || expansion_bad;

   // Next memory map, one field per decoded size
   assign memory_map_d = '{program_bytes:   program_bytes,
                           fast_work_bytes: fast_bytes,
                           expansion_bytes: expansion_bytes,
                           setting_illegal: setting_bad};

   // Read data of the addressed register, zero for any other address
   assign read_data_d =
      memory_size_read ? memory_size_register_q :
      expansion_read   ? expansion_size_register_q :
                         read_idle_value;

   // Memory size register, loaded with the largest map at reset
   always_ff @(posedge clock or negedge reset_n)
   begin
      if (!reset_n)
      begin
         memory_size_register_q <= memory_size_reset;
      end
      else
      begin
         memory_size_register_q <= memory_size_register_d;
      end
   end

   // Expansion size register; its reset value depends on the product
   always_ff @(posedge clock or negedge reset_n)
   begin
      if (!reset_n)
      begin
         expansion_size_register_q <= expansion_reset_value;
      end
      else
      begin
         expansion_size_register_q <= expansion_size_register_d;
      end
   end

   // Read data flop: a value stands for one cycle after the read
   always_ff @(posedge clock or negedge reset_n)
   begin
      if (!reset_n)
      begin
         read_data_q <= read_idle_value;
      end
      else
      begin
         read_data_q <= read_data_d;
      end
   end

   // Map flops: zero in reset, the map shows at the first edge after
   always_ff @(posedge clock or negedge reset_n)
   begin
      if (!reset_n)
      begin
         memory_map_q <= '0;
      end
      else
      begin
         memory_map_q <= memory_map_d;
      end
   end

   // Outputs straight from their flops
   assign read_data  = read_data_q;
   assign memory_map = memory_map_q;

endmodule

// ### testbench/memory_size_asserts.sv
`timescale 1ns/1ps
module memory_size_asserts
(
   input wire logic                            clock,
   input wire logic                            reset_n,
   input wire memory_size_pkg::cpu_access_type cpu_access,
   input wire logic [7:0]                      read_data,
   input wire memory_size_pkg::memory_map_type memory_map
);
   import memory_size_pkg::*;
   // Strobes decoded per register, plus a read strobe for all other addresses
   wire w0 = cpu_access.write && cpu_access.addr == 16'hFFF0;
   wire w4 = cpu_access.write && cpu_access.addr == 16'hFFF4;
   wire r0 = cpu_access.read && cpu_access.addr == 16'hFFF0;
   wire r4 = cpu_access.read && cpu_access.addr == 16'hFFF4;
   wire rx = cpu_access.read && cpu_access.addr != 16'hFFF0 &&
             cpu_access.addr != 16'hFFF4;
   wire [3:0] wd = cpu_access.wdata[3:0];
   default clocking @(posedge clock); endclocking
   default disable iff (!reset_n);
   AST_P32: assert property (w0 && wd == 4'h8 |-> ##2
      memory_map.program_bytes == 16'h8000) else $error("32K map");
   AST_P48: assert property (w0 && wd == 4'hC |-> ##2
      memory_map.program_bytes == 16'hC000) else $error("48K map");
   AST_P60: assert property (w0 && wd == 4'hF |-> ##2
      memory_map.program_bytes == 16'hF000) else $error("60K map");
   AST_FAST: assert property (w0 && cpu_access.wdata[7:5] != 3'h6
      |-> ##2 memory_map.setting_illegal) else $error("fast code");
   AST_X480: assert property (w4 && wd == 4'hB |-> ##2
      memory_map.expansion_bytes == 16'h01E0) else $error("480 map");
   AST_X2016: assert property (w4 && wd == 4'h8 |-> ##2
      memory_map.expansion_bytes == 16'h07E0) else $error("2016 map");
   AST_MZERO: assert property (r0 |=> !read_data[4])
      else $error("bit 4 set");
   AST_XZERO: assert property (r4 |=> read_data[7:4] == 4'h0)
      else $error("upper bits set");
   AST_UNMAP: assert property (rx |=> read_data == 8'h00)
      else $error("unmapped read");
endmodule
bind memory_size_config_regs memory_size_asserts chk (.*);

// ### testbench/tb_top.sv
`timescale 1ns/1ps
module tb_top;
   import memory_size_pkg::*;
   logic           clock = 0;
   logic           reset_n = 0;
   cpu_access_type ca = '0;
   logic [7:0]     rdat;
   memory_map_type map;
   logic [7:0]     rdat_m;
   memory_map_type map_m;
   int             fail_count = 0;
   int             tests_run = 0;
   memory_size_config_regs dut (.clock(clock), .reset_n(reset_n),
      .cpu_access(ca), .read_data(rdat), .memory_map(map));
   // Mask-ROM build: only its expansion reset value differs
   memory_size_config_regs #(.flash_variant(1'b0)) mask_dut (.clock(clock),
      .reset_n(reset_n), .cpu_access(ca), .read_data(rdat_m),
      .memory_map(map_m));
   // Free running clock
   always #5 clock = ~clock;
   task chk(string n, logic [15:0] s, logic [15:0] e);
      tests_run++;
      if (s !== e)
      begin
         fail_count++;
         $display("wrong value %s exp %h got %h", n, e, s);
      end
   endtask
   // One byte access; returns just after the edge that takes it,
   // while the read data stands
   task acc(logic w, logic [15:0] a, logic [7:0] d);
      @(posedge clock);
      ca <= '{w, !w, a, d};
      @(posedge clock);
      ca <= '0;
      #1;
   endtask
   task rd(logic [15:0] a, logic [7:0] e);
      acc(0, a, 8'h00);
      chk("read", {8'h00, rdat}, {8'h00, e});
      @(posedge clock);
      #1;
      chk("read idle", {8'h00, rdat}, 16'h0000);
   endtask
   task wrm(logic [15:0] a, logic [7:0] d);
      acc(1, a, d);
      @(posedge clock);
      #1;
   endtask
   task t_reset;
      chk("map", map.program_bytes, 16'hF000);
      chk("fast map", map.fast_work_bytes, 16'h0400);
      chk("exp map", map.expansion_bytes, 16'h07E0);
      chk("legal", {15'h0, map.setting_illegal}, 16'h0);
      chk("mask map", map_m.expansion_bytes, 16'h0000);
      chk("mask flag", {15'h0, map_m.setting_illegal}, 16'h1);
      acc(0, 16'hFFF4, 8'h00);
      chk("mask reset", {8'h00, rdat_m}, 16'h000C);
      chk("flash reset", {8'h00, rdat}, 16'h0008);
      rd(16'hFFF0, 8'hCF);
      rd(16'hFFF4, 8'h08);
      $display("reset test done");
   endtask
   task automatic t_mem;
      logic [7:0]  c[3] = '{8'hC8, 8'hCC, 8'hCF};
      logic [15:0] b[3] = '{16'h8000, 16'hC000, 16'hF000};
      foreach (c[i])
      begin
         wrm(16'hFFF0, c[i]);
         chk("prog", map.program_bytes, b[i]);
         chk("fast", map.fast_work_bytes, 16'h0400);
         chk("prog ok", {15'h0, map.setting_illegal}, 16'h0);
         rd(16'hFFF0, c[i]);
      end
      chk("60k", map.program_bytes, 16'hF000);
      wrm(16'hFFF0, 8'hAF);
      chk("bad", {15'h0, map.setting_illegal}, 16'h1);
      $display("memory size test done");
   endtask
   task t_exp;
      wrm(16'hFFF0, 8'hCF);
      wrm(16'hFFF4, 8'h0C);
      chk("xbad", map.expansion_bytes, 16'h0000);
      chk("xflag", {15'h0, map.setting_illegal}, 16'h1);
      wrm(16'hFFF4, 8'h0B);
      chk("x480", map.expansion_bytes, 16'h01E0);
      rd(16'hFFF4, 8'h0B);
      wrm(16'hFFF4, 8'h08);
      chk("x2016", map.expansion_bytes, 16'h07E0);
      chk("xok", {15'h0, map.setting_illegal}, 16'h0);
      $display("expansion test done");
   endtask
   task t_bits;
      wrm(16'hFFF0, 8'hFF);
      rd(16'hFFF0, 8'hEF);
      wrm(16'hFFF4, 8'hF8);
      rd(16'hFFF4, 8'h08);
      rd(16'hFFF2, 8'h00);
      rd(16'h0123, 8'h00);
      $display("reserved bit test done");
   endtask
   // Reset in mid-run: registers return to their reset values
   task t_rerun;
      wrm(16'hFFF0, 8'hC8);
      wrm(16'hFFF4, 8'h0B);
      @(posedge clock);
      reset_n <= 1'b0;
      @(posedge clock);
      #1;
      chk("rst map", map.program_bytes, 16'h0000);
      chk("rst read", {8'h00, rdat}, 16'h0000);
      @(posedge clock);
      reset_n <= 1'b1;
      @(posedge clock);
      #1;
      t_reset;
      $display("mid-run reset test done");
   endtask
   task summarize;
      $display("checks %0d mismatches %0d", tests_run, fail_count);
      if (fail_count == 0 && tests_run > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   // Main sequence and watchdog
   initial
   begin
      repeat (8) @(posedge clock);
      reset_n <= 1'b1;
      @(posedge clock);
      #1;
      t_reset;
      t_mem;
      t_exp;
      t_bits;
      t_rerun;
      summarize;
   end
   initial
   begin
      #20000;
      fail_count++;
      summarize;
   end
endmodule
